// File: hdl/rsfa_frame_assembler.sv
// radio science frame assembler: sampling, power, tags, downconversion and byte framing
// assumes a 40 MHz clock, a converter sample valid every fourth clock and a
// downstream that takes one byte per clock whenever stream_o.valid is high
//
// Behaviour
// - every frame is exactly 5082 bytes, each byte belonging to some field
// - first frame byte is always the identifier 0xB7
// - fourth byte is status: selection in bits 6..4, other bits zero
// - selection 000 uses converter samples, any other a fixed test signal
// - selection 001: two samples of 128 at frame start, then zeros
// - selections 010, 011, 110: square waves of +/-256 at three frequencies
// - 100 gives +/-1 random, 101 full-scale random, 111 only zeros
// - power sums the square of every sample of the selected source
// - power is unsigned 40 bits, cleared each frame, ten five-byte snapshots
// - snapshots every 102.4 ms, first at frame start holding previous total
// - 24-bit tag starts at zero on start, counts every 102.4 ms
// - second frame's first tag is 10, third frame's is 20
// - 1250 signed 16-bit I/Q pairs per frame, two bytes each
// - mix 2.5 MHz carrier to zero frequency then fixed baseband filter
// - multi-byte fields are whole bytes, most significant byte first
// - power value bytes at 7,10,13,16,19, then every 508 bytes
// - time tag bytes at 22,25,28, then every 508 bytes
// - I/Q bytes fill all other bytes in order, I then Q
// - start on the next second strobe, then one frame per 1.024 s

`timescale 1ns/1ps

module rsfa_frame_assembler
	import rsfa_pkg::*;
#(
	parameter int PAIR_SAMPLES = PAIR_SAMPLES_DEF  // samples per I/Q pair, >= 16
)
(
	input  wire logic                       clk_i,            // stable oscillator clock
	input  wire logic                       rst_i,            // sync reset, high
	input  wire logic                       second_strobe_i,  // one pulse per second
	input  wire logic                       adc_valid_i,      // unused qualifier slot
	input  wire logic signed [SAMPLE_W-1:0] adc_i,            // converter sample
	input  wire logic [SEL_W-1:0]           input_select_i,   // commanded source
	output rsfa_byte_type                   stream_o,         // output frame bytes
	output logic                            running_o         // frames being produced
);

	// ****************************************
	// derived sizes
	// ****************************************
	localparam int PAIR_LOG2  = $clog2(PAIR_SAMPLES);
	localparam int ACC_W      = SAMPLE_W + PAIR_LOG2 + 1;
	localparam int IQ_SHIFT   = PAIR_LOG2 + 1 - IQ_GAIN_SHIFT;
	localparam int PK_W       = $clog2(PAIRS_PER_FRAME);
	localparam int POS_W      = $clog2(PAIRS_PER_CHUNK);
	localparam int GRP_W      = 8 * GROUP_WIDE;
	localparam int GLEN_W     = $clog2(GROUP_WIDE + 1);
	localparam int RT_W       = POWER_W + TAG_W;
	localparam int DIV_W      = $clog2(SAMPLE_DIV);

	// ****************************************
	// sample rate divider
	// ****************************************
	logic [DIV_W-1:0] div_r;
	logic             sample_en;

	// every slower rate comes from this one enable
	assign sample_en = (div_r == DIV_W'(SAMPLE_DIV - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= '0;
		end else begin
			div_r <= sample_en ? '0 : div_r + DIV_W'(1);
		end
	end

	// ****************************************
	// start control
	// ****************************************
	rsfa_state_type state_r;
	logic           start_now;

	assign start_now = (state_r == ST_IDLE) && second_strobe_i;
	assign running_o = (state_r == ST_RUN);

	// later strobes are ignored: the frame clock free-runs from the first one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: if (second_strobe_i) begin
					state_r <= ST_RUN;
				end
				ST_RUN:  state_r <= ST_RUN;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// frame position counters
	// ****************************************
	logic [PAIR_LOG2-1:0] pair_cnt_r;
	logic [PK_W-1:0]      pair_k_r;
	logic [POS_W-1:0]     chunk_pos_r;
	logic [POS_W-1:0]     byte_pos_r;
	logic                 run_se;
	logic                 frame_start_now;
	logic                 chunk_start_now;
	logic                 pair_done;

	assign run_se          = sample_en && running_o;
	assign frame_start_now = run_se && pair_cnt_r == '0 && pair_k_r == '0;
	assign chunk_start_now = run_se && pair_cnt_r == '0 && chunk_pos_r == '0;
	assign pair_done       = run_se && pair_cnt_r == PAIR_LOG2'(PAIR_SAMPLES - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i || start_now) begin
			pair_cnt_r  <= '0;
			pair_k_r    <= '0;
			chunk_pos_r <= '0;
		end else if (run_se) begin
			pair_cnt_r <= pair_done ? '0 : pair_cnt_r + PAIR_LOG2'(1);
			if (pair_done) begin
				pair_k_r    <= (pair_k_r == PK_W'(PAIRS_PER_FRAME - 1)) ? '0 : pair_k_r + PK_W'(1);
				chunk_pos_r <= (chunk_pos_r == POS_W'(PAIRS_PER_CHUNK - 1)) ? '0 : chunk_pos_r + POS_W'(1);
			end
		end
	end

	// byte chunks lag sample chunks by one pair, since the head group opens the frame
	always_ff @(posedge clk_i) begin
		if (rst_i || start_now) begin
			byte_pos_r <= '0;
		end else if (pair_done) begin
			if (pair_k_r == '0 || byte_pos_r == POS_W'(PAIRS_PER_CHUNK - 1)) begin
				byte_pos_r <= '0;
			end else begin
				byte_pos_r <= byte_pos_r + POS_W'(1);
			end
		end
	end

	// ****************************************
	// source selection
	// ****************************************
	rsfa_sel_type                sel_r;
	rsfa_sel_type                sel_now;
	logic signed [SAMPLE_W-1:0]  test_sample;
	logic signed [SAMPLE_W-1:0]  x;
	logic                        impulse_win;

	// selection is frozen for a whole frame so the status byte matches the data
	assign sel_now     = frame_start_now ? rsfa_sel_type'(input_select_i) : sel_r;
	assign impulse_win = pair_k_r == '0 && pair_cnt_r < PAIR_LOG2'(IMPULSE_LEN);
	assign x           = (sel_now == SEL_ADC) ? adc_i : test_sample;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_r <= SEL_ADC;
		end else if (frame_start_now) begin
			sel_r <= rsfa_sel_type'(input_select_i);
		end
	end

	rsfa_test_source u_test_source (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.restart_i   (start_now),
		.sample_en_i (run_se),
		.sel_i       (sel_now),
		.impulse_i   (impulse_win),
		.sample_o    (test_sample)
	);

	// ****************************************
	// integrated power and time tags
	// ****************************************
	logic [POWER_W-1:0]        power_acc_r;
	logic [POWER_W-1:0]        power_snap_r;
	logic [TAG_W-1:0]          tag_cnt_r;
	logic [TAG_W-1:0]          tag_snap_r;
	logic signed [2*SAMPLE_W-1:0] sq_signed;
	logic [POWER_W-1:0]        sq;

	assign sq_signed = x * x;
	assign sq        = POWER_W'(unsigned'(sq_signed));

	// the snapshot at frame start sees the old total before the clear
	always_ff @(posedge clk_i) begin
		if (rst_i || start_now) begin
			power_acc_r <= '0;
		end else if (frame_start_now) begin
			power_acc_r <= sq;
		end else if (run_se) begin
			power_acc_r <= power_acc_r + sq;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_snap_r <= '0;
		end else if (chunk_start_now) begin
			power_snap_r <= power_acc_r;
		end
	end

	// tag rolls over after about 20 days; never cleared by frames
	always_ff @(posedge clk_i) begin
		if (rst_i || start_now) begin
			tag_cnt_r  <= '0;
			tag_snap_r <= '0;
		end else if (chunk_start_now) begin
			tag_snap_r <= tag_cnt_r;
			tag_cnt_r  <= tag_cnt_r + TAG_W'(1);
		end
	end

	// ****************************************
	// downconversion
	// ****************************************
	logic [1:0]              lo_r;
	logic signed [ACC_W-1:0] xe;
	logic signed [ACC_W-1:0] term_i;
	logic signed [ACC_W-1:0] term_q;
	logic signed [ACC_W-1:0] i_acc_r;
	logic signed [ACC_W-1:0] q_acc_r;
	logic signed [ACC_W-1:0] i_sum;
	logic signed [ACC_W-1:0] q_sum;
	logic [IQ_W-1:0]         i_val;
	logic [IQ_W-1:0]         q_val;

	assign xe = ACC_W'(x);

	// a quarter-rate carrier needs no multiplier: the local oscillator is 1,0,-1,0
	always_comb begin
		unique case (lo_r)
			2'h0: begin term_i = xe; term_q = '0; end
			2'h1: begin term_i = '0; term_q = -xe; end
			2'h2: begin term_i = -xe; term_q = '0; end
			default: begin term_i = '0; term_q = xe; end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || start_now) begin
			lo_r <= '0;
		end else if (run_se) begin
			lo_r <= lo_r + 2'h1;
		end
	end

	// boxcar integrate-and-dump is the fixed baseband filter and decimator
	always_ff @(posedge clk_i) begin
		if (rst_i || start_now) begin
			i_acc_r <= '0;
			q_acc_r <= '0;
		end else if (run_se) begin
			i_acc_r <= (pair_cnt_r == '0) ? term_i : i_acc_r + term_i;
			q_acc_r <= (pair_cnt_r == '0) ? term_q : q_acc_r + term_q;
		end
	end

	assign i_sum = i_acc_r + term_i;
	assign q_sum = q_acc_r + term_q;
	assign i_val = IQ_W'(i_sum >>> IQ_SHIFT);
	assign q_val = IQ_W'(q_sum >>> IQ_SHIFT);

	// ****************************************
	// byte group builder
	// ****************************************
	logic [GRP_W-1:0]  grp_next;
	logic [GLEN_W-1:0] len_next;
	logic [7:0]        status_byte;
	logic [RT_W-1:0]   rt_word;
	logic [7:0]        rt_a;
	logic [7:0]        rt_b;
	logic [POS_W:0]    rt_idx;

	assign status_byte = 8'(sel_r) << STATUS_SEL_LSB;
	assign rt_word     = {power_snap_r, tag_snap_r};
	assign rt_idx      = {byte_pos_r, 1'b0};
	assign rt_a        = rt_word[RT_W - 1 - 8 * rt_idx -: 8];
	assign rt_b        = rt_word[RT_W - 9 - 8 * rt_idx -: 8];

	always_comb begin
		if (pair_k_r == '0) begin
			grp_next = {FRAME_ID, i_val, status_byte, q_val};
			len_next = GLEN_W'(GROUP_WIDE);
		end else if (byte_pos_r < POS_W'(WIDE_PAIRS)) begin
			grp_next = {rt_a, i_val, rt_b, q_val};
			len_next = GLEN_W'(GROUP_WIDE);
		end else begin
			grp_next = {i_val, q_val, 16'h0000};
			len_next = GLEN_W'(GROUP_NARROW);
		end
	end

	// ****************************************
	// byte serializer
	// ****************************************
	logic [GRP_W-1:0]  grp_r;
	logic [GLEN_W-1:0] left_r;
	logic              head_r;

	// a group of at most six bytes drains long before the next pair is ready
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grp_r  <= '0;
			left_r <= '0;
			head_r <= 1'b0;
		end else if (pair_done) begin
			grp_r  <= grp_next;
			left_r <= len_next;
			head_r <= (pair_k_r == '0);
		end else if (left_r != '0) begin
			grp_r  <= grp_r << 8;
			left_r <= left_r - GLEN_W'(1);
			head_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stream_o <= '0;
		end else begin
			stream_o.valid <= (left_r != '0) && !pair_done;
			stream_o.first <= head_r && (left_r != '0) && !pair_done;
			stream_o.data  <= grp_r[GRP_W-1 -: 8];
		end
	end

endmodule

// File: hdl/rsfa_test_source.sv
// selectable deterministic test signal generator
// assumes sample_en_i pulses once per converter sample and restart_i once at start

`timescale 1ns/1ps

module rsfa_test_source
	import rsfa_pkg::*;
(
	input  wire logic                       clk_i,        // system clock
	input  wire logic                       rst_i,        // sync reset, high
	input  wire logic                       restart_i,    // reseed and rephase
	input  wire logic                       sample_en_i,  // one pulse per sample
	input  wire rsfa_sel_type               sel_i,        // source selection
	input  wire logic                       impulse_i,    // inside impulse window
	output logic signed [SAMPLE_W-1:0]      sample_o      // test sample
);

	// ****************************************
	// state
	// ****************************************
	logic [LFSR_W-1:0]   lfsr_r;
	logic [SQ_CNT_W-1:0] sq_cnt_r;
	logic                sq_neg_r;
	logic [SQ_CNT_W-1:0] sq_half;

	always_comb begin
		unique case (sel_i)
			SEL_SQ_MID:  sq_half = SQ_CNT_W'(SQ_HALF_MID);
			SEL_SQ_HIGH: sq_half = SQ_CNT_W'(SQ_HALF_HIGH);
			default:     sq_half = SQ_CNT_W'(SQ_HALF_LOW);
		endcase
	end

	// reseeding at each start keeps test frames reproducible bit for bit
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			lfsr_r <= LFSR_SEED;
		end else if (sample_en_i) begin
			lfsr_r <= {lfsr_r[LFSR_W-2:0], lfsr_r[LFSR_W-1] ^ lfsr_r[LFSR_TAP]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			sq_cnt_r <= '0;
			sq_neg_r <= 1'b0;
		end else if (sample_en_i) begin
			if (sq_cnt_r >= sq_half - SQ_CNT_W'(1)) begin
				sq_cnt_r <= '0;
				sq_neg_r <= ~sq_neg_r;
			end else begin
				sq_cnt_r <= sq_cnt_r + SQ_CNT_W'(1);
			end
		end
	end

	// ****************************************
	// output mux
	// ****************************************
	always_comb begin
		unique case (sel_i)
			SEL_IMPULSE:  sample_o = impulse_i ? SAMPLE_W'(IMPULSE_VAL) : '0;
			SEL_SQ_LOW,
			SEL_SQ_MID,
			SEL_SQ_HIGH:  sample_o = sq_neg_r ? -SAMPLE_W'(SQ_AMP) : SAMPLE_W'(SQ_AMP);
			SEL_PRN_UNIT: sample_o = lfsr_r[0] ? -SAMPLE_W'(1) : SAMPLE_W'(1);
			SEL_PRN_FULL: sample_o = signed'(lfsr_r[SAMPLE_W-1:0]);
			default:      sample_o = '0;
		endcase
	end

endmodule

// File: shared/rsfa_pkg.sv
// constants and types for the radio science frame assembler
// assumes a single 40 MHz clock and a 10 Msample/s converter stream

package rsfa_pkg;

	// ****************************************
	// rates and times
	// ****************************************
	localparam longint CLK_HZ          = 40_000_000;
	localparam longint SAMPLE_RATE_HZ  = 10_000_000;
	localparam int     SAMPLE_DIV      = int'(CLK_HZ / SAMPLE_RATE_HZ);
	localparam longint NS_PER_S        = 1_000_000_000;
	localparam longint US_PER_S        = 1_000_000;
	localparam longint FRAME_TIME_US   = 1_024_000;
	localparam longint TAG_TIME_US     = 102_400;
	localparam longint FRAME_SAMPLES   = FRAME_TIME_US * SAMPLE_RATE_HZ / US_PER_S;
	localparam longint TAG_SAMPLES     = TAG_TIME_US * SAMPLE_RATE_HZ / US_PER_S;

	// ****************************************
	// frame layout
	// ****************************************
	localparam int     FRAME_BYTES     = 5082;
	localparam int     PAIRS_PER_FRAME = 1250;
	localparam int     CHUNKS          = 10;
	localparam int     PAIRS_PER_CHUNK = PAIRS_PER_FRAME / CHUNKS;
	localparam int     PAIR_SAMPLES_DEF = int'(FRAME_SAMPLES / PAIRS_PER_FRAME);
	localparam int     WIDE_PAIRS      = 4;
	localparam int     GROUP_WIDE      = 6;
	localparam int     GROUP_NARROW    = 4;
	localparam logic [7:0] FRAME_ID    = 8'hB7;
	localparam int     STATUS_SEL_LSB  = 4;

	// ****************************************
	// data widths
	// ****************************************
	localparam int     SAMPLE_W        = 12;
	localparam int     IQ_W            = 16;
	localparam int     IQ_GAIN_SHIFT   = IQ_W - SAMPLE_W;
	localparam int     POWER_W         = 40;
	localparam int     TAG_W           = 24;
	localparam int     SEL_W           = 3;

	// ****************************************
	// test sources
	// ****************************************
	localparam int     IMPULSE_VAL     = 128;
	localparam int     IMPULSE_LEN     = 2;
	localparam int     SQ_AMP          = 256;
	localparam longint SQ_LOW_NHZ      = 64'd610_351_562_500;
	localparam longint SQ_MID_NHZ      = 64'd19_531_250_000_000;
	localparam longint SQ_HIGH_NHZ     = 64'd78_125_000_000_000;
	localparam int     SQ_CNT_W        = 14;
	localparam int     SQ_HALF_LOW     = int'(SAMPLE_RATE_HZ * NS_PER_S / (2 * SQ_LOW_NHZ));
	localparam int     SQ_HALF_MID     = int'(SAMPLE_RATE_HZ * NS_PER_S / (2 * SQ_MID_NHZ));
	localparam int     SQ_HALF_HIGH    = int'(SAMPLE_RATE_HZ * NS_PER_S / (2 * SQ_HIGH_NHZ));
	localparam int     LFSR_W          = 23;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h2AAAAA;
	localparam int     LFSR_TAP        = 17;

	typedef enum logic [SEL_W-1:0] {
		SEL_ADC = 3'h0, SEL_IMPULSE = 3'h1, SEL_SQ_LOW = 3'h2, SEL_SQ_MID = 3'h3,
		SEL_PRN_UNIT = 3'h4, SEL_PRN_FULL = 3'h5, SEL_SQ_HIGH = 3'h6, SEL_ZERO = 3'h7
	} rsfa_sel_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} rsfa_state_type;

	typedef struct packed {
		logic       valid;
		logic       first;
		logic [7:0] data;
	} rsfa_byte_type;

endpackage

// File: tb/rsfa_frame_checker.sv
// concurrent checks on the frame assembler output stream
// sees only the assembler ports; attached by the bind at the foot

`timescale 1ns/1ps

module rsfa_frame_checker
	import rsfa_pkg::*;
#(
	parameter int PAIR_SAMPLES = PAIR_SAMPLES_DEF  // samples per pair
)
(
	input  wire logic          clk_i,            // clock
	input  wire logic          rst_i,            // sync reset, high
	input  wire logic          second_strobe_i,  // start strobe
	input  wire rsfa_byte_type stream_o,         // frame bytes
	input  wire logic          running_o         // producing frames
);
	// ********
	// helpers
	// ********
	logic [3:0]  run_r;
	logic [15:0] cnt_r;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			run_r <= 4'h0;
		else if (stream_o.valid)
			run_r <= run_r + 4'h1;
		else
			run_r <= 4'h0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_r <= 16'h0000;
		else if (stream_o.valid && stream_o.first)
			cnt_r <= 16'h0001;
		else if (stream_o.valid)
			cnt_r <= cnt_r + 16'h0001;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ********
	// properties
	// ********
	sequence s_id;
		stream_o.valid && stream_o.data == FRAME_ID;
	endsequence
	sequence s_status;
		stream_o.valid && !stream_o.data[7] && stream_o.data[3:0] == 4'h0;
	endsequence
	sequence s_group6;
		stream_o.valid[*6] ##1 !stream_o.valid;
	endsequence

	property p_idle_quiet;
		!running_o |-> !stream_o.valid;
	endproperty
	property p_start;
		!running_o && second_strobe_i |=> running_o;
	endproperty
	property p_keep_running;
		running_o |=> running_o;
	endproperty
	property p_head_id;
		stream_o.first |-> s_id;
	endproperty
	property p_status_zero;
		stream_o.first |-> ##3 s_status;
	endproperty
	property p_head_group;
		stream_o.first |-> s_group6;
	endproperty
	property p_run_max;
		stream_o.valid |-> run_r < 4'h6;
	endproperty
	property p_run_len;
		$fell(stream_o.valid) && !$past(rst_i) |-> run_r == 4'h4 || run_r == 4'h6;
	endproperty
	property p_group_gap;
		$fell(stream_o.valid) |-> !stream_o.valid[*8];
	endproperty
	property p_frame_len;
		stream_o.valid && stream_o.first |-> cnt_r == 16'h0000 || cnt_r == 16'(FRAME_BYTES);
	endproperty

	a_idle_quiet: assert property (p_idle_quiet) else $error("bytes before start");
	a_start: assert property (p_start) else $error("strobe did not start");
	a_keep_running: assert property (p_keep_running) else $error("production stopped");
	a_head_id: assert property (p_head_id) else $error("bad identifier byte");
	a_status_zero: assert property (p_status_zero) else $error("status spare bits set");
	a_head_group: assert property (p_head_group) else $error("head group not six bytes");
	a_run_max: assert property (p_run_max) else $error("byte run too long");
	a_run_len: assert property (p_run_len) else $error("group not four or six bytes");
	a_group_gap: assert property (p_group_gap) else $error("groups too close");
	a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
endmodule

bind rsfa_frame_assembler rsfa_frame_checker #(.PAIR_SAMPLES(PAIR_SAMPLES)) i_rsfa_frame_checker (
	.clk_i(clk_i), .rst_i(rst_i), .second_strobe_i(second_strobe_i),
	.stream_o(stream_o), .running_o(running_o));

// File: tb/rsfa_recorder_model.sv
// far side model: strobe source and recorder that takes every byte
// assumes go_i is raised for one cycle to ask for a strobe

`timescale 1ns/1ps

module rsfa_recorder_model
	import rsfa_pkg::*;
#(
	parameter int STROBE_DELAY = 3  // cycles from request to strobe
)
(
	input  wire logic          clk_i,            // stable oscillator clock
	input  wire logic          rst_i,            // sync reset, high
	input  wire logic          go_i,             // request one strobe
	input  wire rsfa_byte_type stream_i,         // frame bytes in
	output logic               second_strobe_o,  // one-cycle strobe
	output logic [15:0]        frame_len_o       // bytes of last whole frame
);
	logic [7:0]  dly_r;
	logic [15:0] cnt_r;

	// strobe is a lone pulse, low between seconds
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dly_r <= 8'h00;
		else if (go_i)
			dly_r <= 8'(STROBE_DELAY);
		else if (dly_r != 8'h00)
			dly_r <= dly_r - 8'h01;
		second_strobe_o <= !rst_i && dly_r == 8'h01;
	end

	// a recorder has no way to push back, so every valid byte is taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 16'h0000;
			frame_len_o <= 16'h0000;
		end else if (stream_i.valid && stream_i.first) begin
			frame_len_o <= cnt_r;
			cnt_r <= 16'h0001;
		end else if (stream_i.valid) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule

// File: tb/testbench.sv
// self-checking bench for the frame assembler
// expected frame bytes are queued by position and matched as they stream out

`timescale 1ns/1ps

`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module testbench;
	import rsfa_pkg::*;

	localparam int PS         = 16;
	localparam int CHUNK_B    = 508;
	localparam int TIME_LIMIT = 95000;

	typedef struct {int frm; int pos; logic [7:0] val;} rsfa_note_type;

	logic                       clk_i     = 1'b0;
	logic                       rst_i     = 1'b1;
	logic                       go        = 1'b0;
	logic                       hold_adc  = 1'b0;
	logic signed [SAMPLE_W-1:0] adc_i     = '0;
	logic [SEL_W-1:0]           sel       = '0;
	logic [31:0]                seed      = 32'hBB5784B0;
	logic [39:0]                pw;
	logic                       strobe;
	logic                       running_o;
	logic [15:0]                frame_len;
	rsfa_byte_type              stream_o;
	rsfa_note_type              notes[$];
	int                         num_errors = 0;
	int                         cmp_count  = 0;
	int                         cycles     = 0;
	int                         frm        = 0;
	int                         pos        = 0;
	int                         xv;

	always #12.5 clk_i = ~clk_i;

	rsfa_frame_assembler #(.PAIR_SAMPLES(PS)) i_rsfa_frame_assembler (
		.clk_i(clk_i), .rst_i(rst_i), .second_strobe_i(strobe), .adc_valid_i(1'b1), .adc_i(adc_i),
		.input_select_i(sel), .stream_o(stream_o), .running_o(running_o));

	rsfa_recorder_model i_rsfa_recorder_model (
		.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .stream_i(stream_o),
		.second_strobe_o(strobe), .frame_len_o(frame_len));

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// ********
	// stimulus and scoreboard tasks
	// ********
	task automatic note(input int f, input int p, input logic [7:0] v);
		notes.push_back('{f, p, v});
	endtask

	task automatic note_field(input int f, input int p, input int n, input logic [39:0] v);
		for (int k = 0; k < n; k++)
			note(f, p + 3 * k, v[8 * (n - 1 - k) +: 8]);
	endtask

	task automatic note_head(input int f, input logic [SEL_W-1:0] s, input bit iq,
		input logic [15:0] i_v, input logic [15:0] q_v);
		note(f, 1, FRAME_ID);
		// the two bytes of one I/Q value are adjacent, not three apart like power and tag bytes
		if (iq) begin
			note(f, 2, i_v[15:8]);
			note(f, 3, i_v[7:0]);
		end
		note(f, 4, {1'b0, s, 4'h0});
		if (iq) begin
			note(f, 5, q_v[15:8]);
			note(f, 6, q_v[7:0]);
		end
	endtask

	task automatic start_run(input logic [SEL_W-1:0] s);
		rst_i <= 1'b1;
		sel <= s;
		repeat (4) @(negedge clk_i);
		rst_i <= 1'b0;
		go <= 1'b1;
		@(negedge clk_i);
		go <= 1'b0;
	endtask

	task automatic drain(input int limit, input string name);
		int n;
		n = 0;
		while (notes.size() > 0 && n < limit) begin
			@(negedge clk_i);
			n++;
		end
		if (notes.size() > 0) begin
			num_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, notes.size(), 0);
			notes.delete();
		end
		$display("test %s done", name);
	endtask

	task summarize;
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// random converter samples unless a test needs them held
	always @(negedge clk_i) begin
		if (!hold_adc) begin
			seed = xorshift(seed);
			adc_i <= seed[SAMPLE_W-1:0];
		end
	end

	// ********
	// output watcher
	// ********
	always @(posedge clk_i) begin
		cycles++;
		if (cycles >= TIME_LIMIT) begin
			num_errors++;
			summarize();
		end
		if (rst_i) begin
			frm = 0;
			pos = 0;
		end else if (stream_o.valid === 1'b1) begin
			if (stream_o.first === 1'b1) begin
				frm++;
				pos = 1;
			end else begin
				pos++;
			end
			if (notes.size() > 0 && notes[0].frm == frm && notes[0].pos == pos) begin
				`CHECK(stream_o.data, notes[0].val)
				void'(notes.pop_front());
			end
		end
	end

	// ********
	// main sequence
	// ********
	initial begin
		repeat (12) @(negedge clk_i);
		// square, random and zero sources: head group only
		for (int s = 2; s < 8; s++) begin
			start_run(s[SEL_W-1:0]);
			// square waves hold one level over the first pair, so like zeros they mix to I = Q = 0
			note_head(1, s[SEL_W-1:0], s != 4 && s != 5, 16'h0000, 16'h0000);
			drain(400, "test source");
		end
		// held converter value: pair sums cancel, power is count times square
		hold_adc = 1'b1;
		start_run(SEL_ADC);
		xv = adc_i;
		pw = 40'(PAIRS_PER_CHUNK * PS) * 40'(xv * xv);
		note_head(1, SEL_ADC, 1, 16'h0000, 16'h0000);
		note_field(1, 7 + CHUNK_B, 5, pw);
		drain(9000, "converter");
		// impulse with live converter noise that must be ignored
		hold_adc = 1'b0;
		start_run(SEL_IMPULSE);
		note_head(1, SEL_IMPULSE, 1, 16'h0040, 16'hFFC0);
		for (int i = 1; i <= CHUNKS; i++) begin
			if (i > 1)
				note_field(1, 7 + CHUNK_B * (i - 1), 5, 40'h0000008000);
			note_field(1, 22 + CHUNK_B * (i - 1), 3, 40'(i - 1));
		end
		note_head(2, SEL_IMPULSE, 1, 16'h0040, 16'hFFC0);
		note_field(2, 7, 5, 40'h0000008000);
		note_field(2, 22, 3, 40'h000000000A);
		drain(82000, "impulse frames");
		`CHECK(frame_len, 16'(FRAME_BYTES))
		summarize();
	end
endmodule
